// >>> rtl/pasc_pkg.sv
/*
  Package for the AFE and sleep control register bank: register addresses, field positions,
  reset values and the sleep and clock-select state types.
  Assumes a 5-bit management register address and 16-bit register data.
*/
package pasc_pkg;
  localparam logic [4:0] AddrAfeZero = 5'h11;
  localparam logic [4:0] AddrAfeOne = 5'h12;
  localparam logic [4:0] AddrAfeTwo = 5'h13;
  localparam logic [4:0] AddrAfeThree = 5'h14;

  localparam int BitPdSlowOsc = 6;
  localparam int TrimHi = 15;
  localparam int TrimLo = 12;
  localparam int BitDetThresh = 15;
  localparam int BitSleepSlowOsc = 0;
  localparam int BitSleepMethod = 6;
  localparam int BitManualSleep = 5;
  localparam int BitRetainEn = 4;
  localparam int BitSleepEnable = 3;

  localparam logic [15:0] ResetAfeZero = 16'h0000;
  localparam logic [15:0] ResetAfeOne = 16'h0000;
  localparam logic [15:0] ResetAfeTwo = 16'h0000;
  localparam logic [15:0] ResetAfeThree = 16'h0000;
  // bits of 13h that have a retained copy: 9:8 and 1:0
  localparam logic [15:0] RetainMaskTwo = 16'h0303;

  // cycles a clock source is kept low around a switch
  localparam int SwitchQuiet = 2;

  typedef enum logic [1:0] {PascAwake, PascSleep} pasc_sleep_e;
  typedef enum logic [1:0] {PascUseRef, PascDrainRef, PascUseSlow, PascDrainSlow} pasc_clk_e;
endpackage

// >>> rtl/pasc_clk_if.sv
/*
  Interface between the register bank and its clock selector.
  Assumes one management clock; carries the request and the resulting selection.
*/
`timescale 1ns/1ps
`default_nettype none
interface pasc_clk_if;
  logic wantSlow;
  logic slowActive;
  logic gateRef;
  logic gateSlow;
  modport ctrl (output wantSlow, input slowActive, input gateRef, input gateSlow);
  modport sel (input wantSlow, output slowActive, output gateRef, output gateSlow);
endinterface
`default_nettype wire

// >>> rtl/pasc_clk_select.sv
/*
  Clock source selector: moves between reference clock and slow oscillator with both gates
  low for a quiet period, so no shortened pulse reaches the core.
  Assumes gates are applied to clean, low-phase-latched clock gates downstream.
*/
`timescale 1ns/1ps
`default_nettype none
module pasc_clk_select (
  // system
  input wire logic clock,
  input wire logic reset_n,
  // control
  pasc_clk_if.sel clk
);
  typedef struct packed {
    pasc_pkg::pasc_clk_e state;
    logic [3:0] quiet;
    logic gateRef;
    logic gateSlow;
  } pasc_sel_s;

  pasc_sel_s cur, next_cur;

  initial begin
    if (pasc_pkg::SwitchQuiet < 1 || pasc_pkg::SwitchQuiet > 15) $error("bad quiet count");
  end

  always_comb begin
    next_cur = cur;
    unique case (cur.state)
      pasc_pkg::PascUseRef: begin
        if (clk.wantSlow) begin
          next_cur.state = pasc_pkg::PascDrainRef;
          next_cur.gateRef = 1'b0;
          next_cur.quiet = 4'(pasc_pkg::SwitchQuiet);
        end
      end
      pasc_pkg::PascDrainRef: begin
        if (cur.quiet > 4'h1) begin
          next_cur.quiet = cur.quiet - 4'h1;
        end else begin
          next_cur.state = pasc_pkg::PascUseSlow;
          next_cur.gateSlow = 1'b1;
        end
      end
      pasc_pkg::PascUseSlow: begin
        if (!clk.wantSlow) begin
          next_cur.state = pasc_pkg::PascDrainSlow;
          next_cur.gateSlow = 1'b0;
          next_cur.quiet = 4'(pasc_pkg::SwitchQuiet);
        end
      end
      pasc_pkg::PascDrainSlow: begin
        if (cur.quiet > 4'h1) begin
          next_cur.quiet = cur.quiet - 4'h1;
        end else begin
          next_cur.state = pasc_pkg::PascUseRef;
          next_cur.gateRef = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      cur <= '{state: pasc_pkg::PascUseRef, quiet: 4'h0, gateRef: 1'b1, gateSlow: 1'b0};
    end else begin
      cur <= next_cur;
    end
  end

  assign clk.gateRef = cur.gateRef;
  assign clk.gateSlow = cur.gateSlow;
  assign clk.slowActive = cur.gateSlow;

  property p_no_overlap;
    @(posedge clock) disable iff (!reset_n) !(cur.gateRef && cur.gateSlow);
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("both clock gates open");

  property p_quiet_gap;
    @(posedge clock) disable iff (!reset_n) $fell(cur.gateRef) |-> !cur.gateSlow [*2];
  endproperty
  a_quiet_gap: assert property (p_quiet_gap) else $error("slow gate opened too soon");
endmodule
`default_nettype wire

// >>> rtl/pasc_regs.sv
/*
  AFE control and sleep register bank (11h to 14h) with sleep state and clock source control.
  Assumes the serial management engine presents one-cycle read and write strobes with a
  5-bit register address; reads answer on the next cycle.
*/
// Contract
// - power-down slow-oscillator bit swaps the reference for the slow oscillator
// - transmit trim field 15:12 resets to 0000; 1000 largest, 0111 smallest
// - bit 15 of 13h enables high detector threshold; resets to 0
// - sleep slow-oscillator bit runs slow oscillator in ultra-deep sleep
// - method bit 1: enter sleep only by manual sleep bit
// - method bit 0, reset value: enter sleep automatically on no cable energy
// - manual sleep bit 1 enters standby under host method; resets to 0
// - sleep ends only on hardware reset; clearing bit does not wake
// - retained-copy bit enables retained copy of 14h and 13h bits 9:8,1:0
// - bit 3 of 14h enables sleep; cleared forces energy indicator true
`timescale 1ns/1ps
`default_nettype none
module pasc_regs #(
  parameter int DataWidth = 16
) (
  // system
  input wire logic clock,
  input wire logic reset_n,
  // management register access
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [4:0] regAddr,
  input wire logic [DataWidth-1:0] regWdata,
  output logic [DataWidth-1:0] regRdata,
  output logic regRvalid,
  // power and cable status
  input wire logic powerDown,
  input wire logic energyDetected,
  // analog and sleep controls
  output logic [3:0] fastTxLevelTrim,
  output logic detectorHighThreshold,
  output logic cableEnergyIndicator,
  output logic ultraDeepSleep,
  output logic retainedCopyEnable,
  output logic [DataWidth-1:0] retainedSleepCopy,
  output logic [3:0] retainedDetectorBits,
  output logic slowOscActive,
  output logic refClockGate,
  output logic slowClockGate
);
  typedef struct packed {
    logic [15:0] afeZero;
    logic [15:0] afeOne;
    logic [15:0] afeTwo;
    logic [15:0] afeThree;
    logic [15:0] retainThree;
    logic [3:0] retainTwo;
    pasc_pkg::pasc_sleep_e sleep;
    logic [15:0] rdata;
    logic rvalid;
    logic energyInd;
    logic wantSlow;
    logic [3:0] trimOut;
    logic threshOut;
  } pasc_regs_s;

  pasc_regs_s cur, next_cur;
  pasc_clk_if clkSel ();

  initial begin
    if (DataWidth != 16) $error("register width must be 16");
  end

  function automatic logic [15:0] write_field(input logic [15:0] old, input logic [15:0] val);
    write_field = val | (old & 16'h0000);
  endfunction

  always_comb begin
    next_cur = cur;
    next_cur.rvalid = 1'b0;
    if (regWrite) begin
      unique case (regAddr)
        pasc_pkg::AddrAfeZero: next_cur.afeZero = write_field(cur.afeZero, regWdata);
        pasc_pkg::AddrAfeOne: next_cur.afeOne = write_field(cur.afeOne, regWdata);
        pasc_pkg::AddrAfeTwo: next_cur.afeTwo = write_field(cur.afeTwo, regWdata);
        pasc_pkg::AddrAfeThree: next_cur.afeThree = write_field(cur.afeThree, regWdata);
        default: next_cur.rvalid = 1'b0;
      endcase
    end
    if (regRead) begin
      next_cur.rvalid = 1'b1;
      unique case (regAddr)
        pasc_pkg::AddrAfeZero: next_cur.rdata = cur.afeZero;
        pasc_pkg::AddrAfeOne: next_cur.rdata = cur.afeOne;
        pasc_pkg::AddrAfeTwo: next_cur.rdata = cur.afeTwo;
        pasc_pkg::AddrAfeThree: next_cur.rdata = cur.afeThree;
        default: next_cur.rdata = 16'h0000;
      endcase
    end
    if (cur.afeThree[pasc_pkg::BitRetainEn]) begin
      next_cur.retainThree = cur.afeThree;
      next_cur.retainTwo = {cur.afeTwo[9:8], cur.afeTwo[1:0]};
    end
    next_cur.trimOut = cur.afeOne[pasc_pkg::TrimHi:pasc_pkg::TrimLo];
    next_cur.threshOut = cur.afeTwo[pasc_pkg::BitDetThresh];
    next_cur.energyInd = cur.afeThree[pasc_pkg::BitSleepEnable] ? energyDetected : 1'b1;
    // entry is sticky; only reset_n leaves it
    unique case (cur.sleep)
      pasc_pkg::PascAwake: begin
        if (cur.afeThree[pasc_pkg::BitSleepEnable]) begin
          if (cur.afeThree[pasc_pkg::BitSleepMethod]) begin
            if (cur.afeThree[pasc_pkg::BitManualSleep]) next_cur.sleep = pasc_pkg::PascSleep;
          end else if (!energyDetected) begin
            next_cur.sleep = pasc_pkg::PascSleep;
          end
        end
      end
      pasc_pkg::PascSleep: next_cur.sleep = pasc_pkg::PascSleep;
      default: next_cur.sleep = pasc_pkg::PascAwake;
    endcase
    next_cur.wantSlow = (powerDown && cur.afeZero[pasc_pkg::BitPdSlowOsc]) ||
      (cur.sleep == pasc_pkg::PascSleep && cur.afeTwo[pasc_pkg::BitSleepSlowOsc]);
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      cur <= '{afeZero: pasc_pkg::ResetAfeZero, afeOne: pasc_pkg::ResetAfeOne,
               afeTwo: pasc_pkg::ResetAfeTwo, afeThree: pasc_pkg::ResetAfeThree,
               retainThree: 16'h0000, retainTwo: 4'h0, sleep: pasc_pkg::PascAwake,
               rdata: 16'h0000, rvalid: 1'b0, energyInd: 1'b1, wantSlow: 1'b0,
               trimOut: 4'h0, threshOut: 1'b0};
    end else begin
      cur <= next_cur;
    end
  end

  assign clkSel.wantSlow = cur.wantSlow;

  pasc_clk_select u_select (
    .clock(clock),
    .reset_n(reset_n),
    .clk(clkSel.sel)
  );

  assign regRdata = cur.rdata;
  assign regRvalid = cur.rvalid;
  assign fastTxLevelTrim = cur.trimOut;
  assign detectorHighThreshold = cur.threshOut;
  assign cableEnergyIndicator = cur.energyInd;
  assign ultraDeepSleep = (cur.sleep == pasc_pkg::PascSleep);
  assign retainedCopyEnable = cur.afeThree[pasc_pkg::BitRetainEn];
  assign retainedSleepCopy = cur.retainThree;
  assign retainedDetectorBits = cur.retainTwo;
  assign slowOscActive = clkSel.slowActive;
  assign refClockGate = clkSel.gateRef;
  assign slowClockGate = clkSel.gateSlow;

  property p_sleep_sticky;
    @(posedge clock) disable iff (!reset_n) ultraDeepSleep |=> ultraDeepSleep;
  endproperty
  a_sleep_sticky: assert property (p_sleep_sticky) else $error("sleep left without reset");

  property p_manual_entry;
    @(posedge clock) disable iff (!reset_n)
      (!ultraDeepSleep && cur.afeThree[3] && cur.afeThree[6] && cur.afeThree[5]) |=> ultraDeepSleep;
  endproperty
  a_manual_entry: assert property (p_manual_entry) else $error("manual sleep not entered");

  property p_host_only;
    @(posedge clock) disable iff (!reset_n)
      (!ultraDeepSleep && cur.afeThree[6] && !cur.afeThree[5]) |=> !ultraDeepSleep;
  endproperty
  a_host_only: assert property (p_host_only) else $error("sleep entered without manual bit");

  property p_auto_entry;
    @(posedge clock) disable iff (!reset_n)
      (cur.afeThree[3] && !cur.afeThree[6] && !energyDetected) |=> ultraDeepSleep;
  endproperty
  a_auto_entry: assert property (p_auto_entry) else $error("automatic sleep missed");

  property p_indicator_forced;
    @(posedge clock) disable iff (!reset_n) !cur.afeThree[3] |=> cableEnergyIndicator;
  endproperty
  a_indicator_forced: assert property (p_indicator_forced) else $error("indicator not forced");

  property p_trim_follows;
    @(posedge clock) disable iff (!reset_n)
      (regWrite && regAddr == 5'h12) |=> ##1 fastTxLevelTrim == $past(regWdata[15:12], 2);
  endproperty
  a_trim_follows: assert property (p_trim_follows) else $error("trim not applied");

  property p_thresh_follows;
    @(posedge clock) disable iff (!reset_n)
      (regWrite && regAddr == 5'h13) |=> ##1 detectorHighThreshold == $past(regWdata[15], 2);
  endproperty
  a_thresh_follows: assert property (p_thresh_follows) else $error("threshold not applied");

  property p_pd_slow;
    @(posedge clock) disable iff (!reset_n)
      (powerDown && cur.afeZero[6] && !slowOscActive) |-> ##[1:6] slowOscActive;
  endproperty
  a_pd_slow: assert property (p_pd_slow) else $error("slow oscillator not selected");

  property p_sleep_slow;
    @(posedge clock) disable iff (!reset_n)
      (ultraDeepSleep && cur.afeTwo[0] && !powerDown) |-> ##[0:6] slowOscActive;
  endproperty
  a_sleep_slow: assert property (p_sleep_slow) else $error("sleep slow clock missing");

  property p_retain;
    @(posedge clock) disable iff (!reset_n) cur.afeThree[4] |=> retainedSleepCopy == $past(cur.afeThree);
  endproperty
  a_retain: assert property (p_retain) else $error("retained copy stale");

  property p_trim_reset;
    @(posedge clock) disable iff (!reset_n)
      $rose(reset_n) |-> fastTxLevelTrim == pasc_pkg::ResetAfeOne[pasc_pkg::TrimHi:pasc_pkg::TrimLo];
  endproperty
  a_trim_reset: assert property (p_trim_reset) else $error("trim not nominal after reset");

  property p_thresh_reset;
    @(posedge clock) disable iff (!reset_n)
      $rose(reset_n) |-> detectorHighThreshold == pasc_pkg::ResetAfeTwo[pasc_pkg::BitDetThresh];
  endproperty
  a_thresh_reset: assert property (p_thresh_reset) else $error("threshold set after reset");

  property p_sleep_reset;
    @(posedge clock) disable iff (!reset_n)
      $rose(reset_n) |-> !ultraDeepSleep;
  endproperty
  a_sleep_reset: assert property (p_sleep_reset) else $error("still asleep after reset");

  property p_trim_stable;
    @(posedge clock) disable iff (!reset_n)
      $changed(fastTxLevelTrim) |-> $past(regWrite, 2) && $past(regAddr, 2) == pasc_pkg::AddrAfeOne;
  endproperty
  a_trim_stable: assert property (p_trim_stable) else $error("trim changed without write");

  property p_thresh_stable;
    @(posedge clock) disable iff (!reset_n)
      $changed(detectorHighThreshold) |-> $past(regWrite, 2) && $past(regAddr, 2) == pasc_pkg::AddrAfeTwo;
  endproperty
  a_thresh_stable: assert property (p_thresh_stable) else $error("threshold changed without write");

  property p_trim_readback;
    @(posedge clock) disable iff (!reset_n)
      (regRead && regAddr == pasc_pkg::AddrAfeOne) |=> regRvalid && regRdata[15:12] == $past(cur.afeOne[15:12]);
  endproperty
  a_trim_readback: assert property (p_trim_readback) else $error("trim read back wrong");

  property p_energy_follows;
    @(posedge clock) disable iff (!reset_n)
      cur.afeThree[pasc_pkg::BitSleepEnable] |=> cableEnergyIndicator == $past(energyDetected);
  endproperty
  a_energy_follows: assert property (p_energy_follows) else $error("indicator not following energy");

  property p_no_sleep_disabled;
    @(posedge clock) disable iff (!reset_n)
      (!ultraDeepSleep && !cur.afeThree[pasc_pkg::BitSleepEnable]) |=> !ultraDeepSleep;
  endproperty
  a_no_sleep_disabled: assert property (p_no_sleep_disabled) else $error("sleep entered while disabled");

  property p_retain_hold;
    @(posedge clock) disable iff (!reset_n)
      !cur.afeThree[pasc_pkg::BitRetainEn] |=> $stable(retainedSleepCopy) && $stable(retainedDetectorBits);
  endproperty
  a_retain_hold: assert property (p_retain_hold) else $error("retained copy moved while off");

  property p_retain_bits;
    @(posedge clock) disable iff (!reset_n)
      cur.afeThree[pasc_pkg::BitRetainEn] |=> retainedDetectorBits == {$past(cur.afeTwo[9:8]), $past(cur.afeTwo[1:0])};
  endproperty
  a_retain_bits: assert property (p_retain_bits) else $error("retained detector bits stale");

  property p_ref_kept;
    @(posedge clock) disable iff (!reset_n)
      ((!powerDown || !cur.afeZero[pasc_pkg::BitPdSlowOsc]) &&
        !(ultraDeepSleep && cur.afeTwo[pasc_pkg::BitSleepSlowOsc])) |=> !cur.wantSlow;
  endproperty
  a_ref_kept: assert property (p_ref_kept) else $error("slow clock requested while clear");
endmodule
`default_nettype wire

// >>> sim/pasc_host_model.sv
/*
  Management host model: one-cycle register write and read strobes.
  Assumes the bench calls its tasks and owns clock and reset.
*/
`timescale 1ns/1ps
`default_nettype none
module pasc_host_model (
  // system
  input wire logic clock,
  // register access
  output logic regWrite,
  output logic regRead,
  output logic [4:0] regAddr,
  output logic [15:0] regWdata,
  input wire logic [15:0] regRdata,
  input wire logic regRvalid
);
  initial begin
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 5'h00;
    regWdata = 16'h0000;
  end
  // released lines show the inverse, so a stale value never looks valid
  task automatic drop(input logic [4:0] a, input logic [15:0] d);
    regWrite <= 1'b0;
    regRead <= 1'b0;
    regAddr <= ~a;
    regWdata <= ~d;
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clock);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clock);
    drop(a, d);
  endtask
  task automatic rd(input logic [4:0] a, output logic [15:0] d, output logic v);
    @(posedge clock);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    drop(a, regWdata);
    #1;
    d = regRdata;
    v = regRvalid;
  endtask
endmodule
`default_nettype wire

// >>> sim/tb_phy_afe_sleep_control_regs.sv
/*
  Bench for the AFE and sleep register bank, checked against a register model.
  Assumes the design and host model compile first.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin error_cnt++; $display("wrong value at %0t: %h %h", $time, a, b); end end
module tb_phy_afe_sleep_control_regs;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic powerDown = 1'b0;
  logic energyDetected = 1'b1;
  logic regWrite, regRead, regRvalid, rvalid, refPrev, slowPrev;
  logic [4:0] regAddr;
  logic [15:0] regWdata, regRdata, rdata, retainedSleepCopy;
  logic [3:0] fastTxLevelTrim, retainedDetectorBits;
  logic detectorHighThreshold, cableEnergyIndicator, ultraDeepSleep, retainedCopyEnable;
  logic slowOscActive, refClockGate, slowClockGate;
  logic [1:0] quietHist = 2'b00;
  logic [15:0] regModel [17:20];
  int error_cnt = 0;
  int checked = 0;
  int seed = 84;
  always #2.5 clock = ~clock;
  pasc_regs #(.DataWidth(16)) i_pasc_regs (.clock(clock), .reset_n(reset_n), .regWrite(regWrite),
    .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .regRvalid(regRvalid),
    .powerDown(powerDown), .energyDetected(energyDetected), .fastTxLevelTrim(fastTxLevelTrim),
    .detectorHighThreshold(detectorHighThreshold), .cableEnergyIndicator(cableEnergyIndicator),
    .ultraDeepSleep(ultraDeepSleep), .retainedCopyEnable(retainedCopyEnable),
    .retainedSleepCopy(retainedSleepCopy), .retainedDetectorBits(retainedDetectorBits),
    .slowOscActive(slowOscActive), .refClockGate(refClockGate), .slowClockGate(slowClockGate));
  pasc_host_model i_pasc_host_model (.clock(clock), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .regRvalid(regRvalid));
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic put(input logic [4:0] a, input logic [15:0] d);
    logic [15:0] v;
    v = d;
    if (a == pasc_pkg::AddrAfeThree && d[3]) v[4] = 1'b1;
    if (a >= 5'h11 && a <= 5'h14) regModel[a] = v;
    i_pasc_host_model.wr(a, v);
  endtask
  task automatic get(input logic [4:0] a);
    logic [15:0] e;
    e = (a >= 5'h11 && a <= 5'h14) ? regModel[a] : 16'h0000;
    i_pasc_host_model.rd(a, rdata, rvalid);
    `CHK(rvalid, 1'b1)
    `CHK(rdata, e)
  endtask
  task automatic outs();
    logic [15:0] s, t;
    s = regModel[20];
    t = regModel[19];
    repeat (2) @(posedge clock);
    #1;
    `CHK(fastTxLevelTrim, regModel[18][15:12])
    `CHK(detectorHighThreshold, t[15])
    `CHK(retainedCopyEnable, s[4])
    `CHK(cableEnergyIndicator, s[3] ? energyDetected : 1'b1)
    if (s[4]) begin
      `CHK(retainedSleepCopy, s)
      `CHK(retainedDetectorBits, {t[9:8], t[1:0]})
    end
  endtask
  task automatic wait_slow(input logic want);
    for (int n = 0; n < 20 && (slowOscActive !== want || refClockGate !== !want); n++) begin
      @(posedge clock);
      #1;
    end
  endtask
  task automatic do_reset();
    @(posedge clock);
    reset_n <= 1'b0;
    repeat (6) @(posedge clock);
    reset_n <= 1'b1;
    for (int a = 17; a <= 20; a++) regModel[a] = 16'h0000;
    #1;
    `CHK(ultraDeepSleep, 1'b0)
    `CHK(refClockGate, 1'b1)
  endtask
  always @(negedge clock) begin
    if (reset_n === 1'b1 && ((refClockGate && !refPrev) || (slowClockGate && !slowPrev))) `CHK(quietHist, 2'b11)
    `CHK(refClockGate & slowClockGate, 1'b0)
    quietHist <= {quietHist[0], !refClockGate && !slowClockGate};
    refPrev <= refClockGate;
    slowPrev <= slowClockGate;
  end
  initial begin
    #100000;
    error_cnt++;
    give_verdict();
  end
  initial begin
    do_reset();
    for (int a = 16; a <= 21; a++) get(5'(a));
    outs();
    $display("test reset done");
    for (int k = 0; k < 16; k++) begin
      put(5'h12, {k[3:0], 12'($random(seed))});
      put(5'h13, {k[0], 15'($random(seed))}); // high threshold on odd trim codes
      put(5'h11, 16'($random(seed)) & 16'hffbf);
      put(5'h14, 16'($random(seed)) & 16'hff97);
      put(5'h15, 16'($random(seed)));
      @(posedge clock);
      energyDetected <= 1'($random(seed));
      for (int a = 17; a <= 21; a++) get(5'(a));
      outs();
    end
    $display("test fields done");
    @(posedge clock);
    powerDown <= 1'b1;
    repeat (10) @(posedge clock);
    #1;
    `CHK(slowOscActive, 1'b0)
    put(5'h11, 16'h0040);
    wait_slow(1'b1);
    `CHK(slowOscActive, 1'b1)
    `CHK(refClockGate, 1'b0)
    @(posedge clock);
    powerDown <= 1'b0;
    wait_slow(1'b0);
    `CHK(refClockGate, 1'b1)
    $display("test power down done");
    put(5'h13, 16'h0001);
    put(5'h14, 16'h0048);
    @(posedge clock);
    energyDetected <= 1'b0;
    outs();
    `CHK(ultraDeepSleep, 1'b0)
    put(5'h14, 16'h0068);
    outs();
    `CHK(ultraDeepSleep, 1'b1)
    wait_slow(1'b1);
    `CHK(slowOscActive, 1'b1)
    put(5'h14, 16'h0048);
    get(5'h14);
    `CHK(ultraDeepSleep, 1'b1)
    do_reset();
    $display("test manual sleep done");
    @(posedge clock);
    energyDetected <= 1'b1;
    put(5'h14, 16'h0008);
    outs();
    `CHK(ultraDeepSleep, 1'b0)
    @(posedge clock);
    energyDetected <= 1'b0;
    repeat (4) @(posedge clock);
    #1;
    `CHK(ultraDeepSleep, 1'b1)
    `CHK(slowOscActive, 1'b0)
    do_reset();
    $display("test auto sleep done");
    give_verdict();
  end
endmodule
`default_nettype wire
